// ==== hw/wdt_watchdog_timer.sv ====
// Watchdog timer with early interrupt and system reset
`timescale 1ns/1ps
`default_nettype none

module wdt_watchdog_timer
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control register port
  input wire logic ctlWrite,
  input wire logic [WDT_CTL_W-1:0] ctlWdata,
  output logic [WDT_CTL_W-1:0] ctlRdata,
  // Events
  output logic wdtIrq,
  output logic wdtSysReset
);

  // Readback image while in reset: shortest interval, reset enable set
  localparam logic [WDT_CTL_W-1:0] CTL_RESET_IMAGE = {
    1'b0,
    1'b0,
    1'b0,
    1'b0,
    1'b1,
    1'b0,
    WDT_SEL_RESET
  };

  wdt_regs_t r_q;
  wdt_regs_t r_d;
  logic [WDT_CNT_W-1:0] timeout;
  logic [WDT_CNT_W-1:0] warnAt;
  logic [WDT_CNT_W-1:0] fireAt;
  logic restart;
  logic irqClr;
  logic rstClr;
  logic warnHit;
  logic fireHit;

  // Interval select to terminal count
  always_comb
  begin
    case (r_q.sel)
      WDT_SEL_2P12: timeout = WDT_TO_2P12;
      WDT_SEL_2P15: timeout = WDT_TO_2P15;
      WDT_SEL_2P18: timeout = WDT_TO_2P18;
      WDT_SEL_2P21: timeout = WDT_TO_2P21;
      default: timeout = WDT_TO_2P12;
    endcase
  end

  // Counts at which the warning and the reset are launched
  always_comb
  begin
    warnAt = timeout - WDT_IRQ_LEAD - WDT_CNT_ONE;
    fireAt = timeout - WDT_CNT_ONE;
  end

  // Control write decode
  always_comb
  begin
    restart = ctlWrite && ctlWdata[WDT_BIT_RESTART];
    // Flags clear by writing zero to their bit
    irqClr = ctlWrite && !ctlWdata[WDT_BIT_IRQFLAG];
    rstClr = ctlWrite && !ctlWdata[WDT_BIT_RSTFLAG];
  end

  // Threshold matches, only meaningful in their own state
  always_comb
  begin
    warnHit = (r_q.st == WDT_COUNT) && (r_q.cnt == warnAt);
    fireHit = (r_q.st == WDT_WARN) && (r_q.cnt == fireAt);
  end

  always_comb
  begin
    r_d = r_q;
    r_d.irq = 1'b0;
    r_d.sysReset = 1'b0;
    if (ctlWrite)
    begin
      r_d.sel = ctlWdata[WDT_BIT_SEL_HI:WDT_BIT_SEL_LO];
      r_d.irqEn = ctlWdata[WDT_BIT_IRQEN];
      r_d.rstEn = ctlWdata[WDT_BIT_RSTEN];
    end
    // Clears first so that a set in the same cycle wins
    if (irqClr)
    begin
      r_d.irqFlag = 1'b0;
    end
    if (rstClr)
    begin
      r_d.rstFlag = 1'b0;
    end
    if (restart)
    begin
      r_d.cnt = WDT_CNT_ZERO;
      r_d.st = WDT_COUNT;
    end
    else
    begin
      r_d.cnt = r_q.cnt + WDT_CNT_ONE;
      case (r_q.st)
        WDT_COUNT:
        begin
          if (warnHit)
          begin
            r_d.st = WDT_WARN;
            r_d.irqFlag = 1'b1;
          end
        end
        WDT_WARN:
        begin
          if (fireHit)
          begin
            r_d.st = WDT_FIRE;
            r_d.rstFlag = 1'b1;
          end
        end
        WDT_FIRE:
        begin
          // Hold until restart; device reset clears everything
          r_d.cnt = r_q.cnt;
        end
        default:
        begin
          r_d.st = WDT_COUNT;
        end
      endcase
    end
    // Interrupt output gated by enable, level while flag set
    r_d.irq = r_d.irqFlag && r_d.irqEn;
    // Reset follows its flag alone, whatever the enables say
    r_d.sysReset = r_d.rstFlag;
    r_d.rdata = '0;
    r_d.rdata[WDT_BIT_SEL_HI:WDT_BIT_SEL_LO] = r_d.sel;
    r_d.rdata[WDT_BIT_IRQEN] = r_d.irqEn;
    r_d.rdata[WDT_BIT_RSTEN] = r_d.rstEn;
    r_d.rdata[WDT_BIT_IRQFLAG] = r_d.irqFlag;
    r_d.rdata[WDT_BIT_RSTFLAG] = r_d.rstFlag;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r_q.st <= WDT_COUNT;
      r_q.cnt <= WDT_CNT_ZERO;
      r_q.sel <= WDT_SEL_RESET;
      r_q.irqEn <= 1'b0;
      r_q.rstEn <= 1'b1;
      r_q.irqFlag <= 1'b0;
      r_q.rstFlag <= 1'b0;
      r_q.irq <= 1'b0;
      r_q.sysReset <= 1'b0;
      r_q.rdata <= CTL_RESET_IMAGE;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign ctlRdata = r_q.rdata;
  assign wdtIrq = r_q.irq;
  assign wdtSysReset = r_q.sysReset;

endmodule // wdt_watchdog_timer

`default_nettype wire

// ==== hw/wdt_pkg.sv ====
// Constants and types for the watchdog timer
package wdt_pkg;
  // Interval select codes
  localparam logic [1:0] WDT_SEL_2P12 = 2'h0;
  localparam logic [1:0] WDT_SEL_2P15 = 2'h1;
  localparam logic [1:0] WDT_SEL_2P18 = 2'h2;
  localparam logic [1:0] WDT_SEL_2P21 = 2'h3;
  localparam logic [1:0] WDT_SEL_RESET = WDT_SEL_2P12;
  // Counter width covers the longest interval
  localparam int WDT_CNT_W = 22;
  localparam logic [21:0] WDT_TO_2P12 = 22'h001000;
  localparam logic [21:0] WDT_TO_2P15 = 22'h008000;
  localparam logic [21:0] WDT_TO_2P18 = 22'h040000;
  localparam logic [21:0] WDT_TO_2P21 = 22'h200000;
  // Early warning lead before reset
  localparam logic [21:0] WDT_IRQ_LEAD = 22'h000200;
  localparam logic [21:0] WDT_CNT_ZERO = 22'h000000;
  localparam logic [21:0] WDT_CNT_ONE = 22'h000001;

  // Control register bit layout
  localparam int WDT_CTL_W = 8;
  localparam int WDT_BIT_SEL_LO = 0;
  localparam int WDT_BIT_SEL_HI = 1;
  localparam int WDT_BIT_IRQEN = 2;
  localparam int WDT_BIT_RSTEN = 3;
  localparam int WDT_BIT_RESTART = 4;
  localparam int WDT_BIT_IRQFLAG = 5;
  localparam int WDT_BIT_RSTFLAG = 6;

  typedef enum logic [2:0] {
    WDT_COUNT = 3'h1,
    WDT_WARN = 3'h2,
    WDT_FIRE = 3'h4
  } wdt_state_t;

  typedef struct packed {
    wdt_state_t st;
    logic [21:0] cnt;
    logic [1:0] sel;
    logic irqEn;
    logic rstEn;
    logic irqFlag;
    logic rstFlag;
    logic irq;
    logic sysReset;
    logic [7:0] rdata;
  } wdt_regs_t;
endpackage : wdt_pkg

// ==== bench/wdt_watchdog_timer_assertions.sv ====
// Watchdog checker
`timescale 1ns/1ps
`default_nettype none
module wdt_chk
  import wdt_pkg::*;
(
  // Watched ports
  input wire logic clk,
  input wire logic rstn,
  input wire logic ctlWrite,
  input wire logic [7:0] ctlWdata,
  input wire logic [7:0] ctlRdata,
  input wire logic wdtIrq,
  input wire logic wdtSysReset
);
  logic [21:0] age_q;
  wire logic [21:0] tmo = WDT_TO_2P12 << (3 * ctlRdata[1:0]);
  // Mirror of the count since restart
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) age_q <= WDT_CNT_ZERO;
    else age_q <= (ctlWrite && ctlWdata[4]) ? WDT_CNT_ZERO : age_q + WDT_CNT_ONE;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_irq_lead: assert property (
    $rose(wdtIrq) && $past(ctlRdata[2]) |-> age_q == tmo - WDT_IRQ_LEAD) else $error("irq time");
  a_rst_time: assert property (
    $rose(wdtSysReset) && $past(ctlRdata[3]) |-> age_q == tmo) else $error("reset time");
  a_irq_gate: assert property (!ctlRdata[2] |-> !wdtIrq) else $error("irq gate");
  a_rst_gate: assert property (ctlRdata[6] |-> wdtSysReset) else $error("rst gate");
  a_ctl_load: assert property (
    ctlWrite |=> ctlRdata[3:0] == $past(ctlWdata[3:0])) else $error("ctl load");
  a_rst_hold: assert property (wdtSysReset && !ctlWrite |=> wdtSysReset) else $error("rst");
  a_irq_hold: assert property (wdtIrq && !ctlWrite |=> wdtIrq) else $error("irq hold");
endmodule // wdt_chk
bind wdt_watchdog_timer wdt_chk u_chk (.clk(clk), .rstn(rstn), .ctlWrite(ctlWrite),
  .ctlWdata(ctlWdata), .ctlRdata(ctlRdata), .wdtIrq(wdtIrq), .wdtSysReset(wdtSysReset));
`default_nettype wire

// ==== bench/wdt_watchdog_timer_tb.sv ====
// Watchdog bench
`timescale 1ns/1ps
`default_nettype none
module wdt_watchdog_timer_tb
  import wdt_pkg::*;
;
  logic clk = 1'h0, rstn = 1'h0, ctlWrite = 1'h0, wdtIrq, wdtSysReset;
  logic [7:0] ctlWdata = 8'h00, ctlRdata, d;
  int err_count = 0, checks = 0, seed = 87703, cyc = 0, n;
  wdt_watchdog_timer dut (.clk(clk), .rstn(rstn), .ctlWrite(ctlWrite), .ctlWdata(ctlWdata),
    .ctlRdata(ctlRdata), .wdtIrq(wdtIrq), .wdtSysReset(wdtSysReset));
  initial forever #5 clk = ~clk;
  function automatic logic [21:0] tmo(int s);
    return WDT_TO_2P12 << (3 * s);
  endfunction
  task automatic chk(string s, logic [21:0] e, logic [21:0] g);
    checks++;
    if (g !== e)
    begin
      $display("ERROR %s exp %0h got %0h", s, e, g);
      err_count++;
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(logic [7:0] v);
    ctlWrite = 1'h1;
    ctlWdata = v;
    @(posedge clk) #1 ctlWrite = 1'h0;
  endtask
  task automatic waitfor(logic w, int lim);
    n = 0;
    while ((w ? wdtSysReset : wdtIrq) !== 1'h1 && n < lim)
    begin
      @(posedge clk) #1 n++;
    end
  endtask
  always @(posedge clk)
    if (++cyc == 60000)
    begin
      err_count++;
      conclude();
    end
  initial
  begin
    repeat (6) @(posedge clk);
    #1 rstn = 1'h1;
    chk("reset", 22'h008, {wdtIrq, wdtSysReset, ctlRdata});
    for (int i = 0; i < 8; i++)
    begin
      d = 8'h10 | 8'(i % 4) | (8'($random(seed)) & 8'h0C);
      wr(d);
      chk("readback", 22'(d & 8'h0F), 22'(ctlRdata));
      @(posedge clk) #1;
    end
    $display("test readback end");
    repeat (5)
    begin
      wr(8'h1C);
      repeat ($unsigned($random(seed)) % 3000 + 1) @(posedge clk);
      #1;
    end
    chk("serviced", 22'h0, {wdtIrq, wdtSysReset});
    $display("test service end");
    wr(8'h1C);
    waitfor(0, 5000);
    chk("irq lead", tmo(0) - WDT_IRQ_LEAD, 22'(n));
    waitfor(1, 600);
    chk("reset lead", WDT_IRQ_LEAD, 22'(n));
    wr(8'h19);
    waitfor(1, 40000);
    chk("long timeout", tmo(1), {wdtIrq, 21'(n)});
    $display("test timeout end");
    conclude();
  end
endmodule // wdt_watchdog_timer_tb
`default_nettype wire
